/* File: hw/ioc_core.sv */
/*
 I/O channel value conditioner: digital input path and analog output path with
 simulation, error modes and substitute values, reached over AXI4-Lite.
 Assumes synchronous field inputs and one clk_sys domain at 100 MHz.
*/
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
// What this block does
// - Analog output change is limited to the set rate in percent per second.
// - Analog rate zero disables limiting; changes pass straight through.
// - Analog simulation outputs a set percent, held within -25 to 125 percent.
// - Analog simulation invalid flag marks data invalid and starts the error strategy.
// - Analog substitute mode outputs a set percent within -25 to 125 percent on error.
// - Analog substitute value is always marked invalid, with no option.
// - Digital input forwards the field level, or the simulation bit in simulation.
// - Digital simulation is one bit with a selectable OK or invalid status.
// - Digital substitute is one set bit and always sent as invalid.
// - On error the digital input sends live, substitute or last valid value.
// - Negation inverts the digital input level.
// - Enabled line fault detection flags the error and starts the error strategy while digital simulation is off.
// - ON delay in milliseconds filters short rising pulses.
// - OFF delay in milliseconds stretches short high pulses.
// - Channels work only while the module enable is set.
`timescale 1ns/1ps
`default_nettype none
module ioc_core #(
   parameter int MS_CYCLES = ioc_pkg::MS_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output wire logic s_axi_wready,
   output wire logic [1:0] s_axi_bresp,
   output wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output wire logic s_axi_arready,
   output wire logic [31:0] s_axi_rdata,
   output wire logic [1:0] s_axi_rresp,
   output wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic di_field,
   input wire logic di_line_fault,
   input wire logic [15:0] ao_bus_value,
   input wire logic ao_bus_ok,
   input wire logic ao_error,
   output wire logic di_value,
   output wire logic di_value_ok,
   output wire logic [15:0] ao_value,
   output wire logic ao_value_ok,
   output wire logic irq
);
   localparam int MSW = $clog2(MS_CYCLES);

   if (MS_CYCLES < 2) begin : g_chk
      $error("MS_CYCLES must be at least 2");
   end

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic arready;
      logic rvalid;
      logic aw_hold;
      logic w_hold;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [1:0] bresp;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [12:0] ctrl;
      logic [15:0] on_dly;
      logic [15:0] off_dly;
      logic [15:0] rate;
      logic [15:0] ao_sim;
      logic [15:0] ao_subst;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic irq;
      logic [MSW-1:0] ms_cnt;
      logic ms_tick;
      logic [3:0] step_cnt;
      logic rate_tick;
      logic di_filt;
      logic [15:0] di_cnt;
      logic di_pv;
      logic di_ok;
      logic di_last;
      logic di_fault;
      logic [15:0] ao_tgt;
      logic [15:0] ao_last;
      logic ao_ok;
   } ioc_state_type;

   ioc_state_type s;
   ioc_state_type nxt_s;
   ioc_ramp_if rif ();

   logic en;
   logic di_live;
   logic di_err;
   logic [1:0] di_mode;
   logic [1:0] ao_mode;
   logic [15:0] ao_src;
   logic ao_err;
   logic wr_go;
   logic [31:0] wr_word;
   logic [2:0] irq_clr;
   logic [2:0] ev;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] clamp_pct(input logic [15:0] v);
      logic [15:0] r;
      r = v;
      if ($signed(v) < $signed(ioc_pkg::PCT_MIN)) begin
         r = ioc_pkg::PCT_MIN;
      end else if ($signed(v) > $signed(ioc_pkg::PCT_MAX)) begin
         r = ioc_pkg::PCT_MAX;
      end
      return r;
   endfunction

   always_comb begin
      nxt_s = s;
      en = s.ctrl[ioc_pkg::B_EN];
      di_mode = s.ctrl[ioc_pkg::B_DI_MODE +: 2];
      ao_mode = s.ctrl[ioc_pkg::B_AO_MODE +: 2];
      wr_go = s.aw_hold && s.w_hold && !s.bvalid;
      wr_word = merge(32'h00000000, s.wdata, s.wstrb);
      irq_clr = 3'h0;

      // Address and data may arrive in either order; each is held until both are in
      if (s_axi_awvalid && s.awready) begin
         nxt_s.aw_hold = 1'b1;
         nxt_s.waddr = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s.wready) begin
         nxt_s.w_hold = 1'b1;
         nxt_s.wdata = s_axi_wdata;
         nxt_s.wstrb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready) begin
         nxt_s.bvalid = 1'b0;
      end
      if (wr_go) begin
         nxt_s.aw_hold = 1'b0;
         nxt_s.w_hold = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = ioc_pkg::RESP_OK;
         unique case (s.waddr)
            ioc_pkg::OFS_CTRL: nxt_s.ctrl = 13'(merge({19'h00000, s.ctrl}, s.wdata, s.wstrb));
            ioc_pkg::OFS_ON_DLY: nxt_s.on_dly = 16'(merge({16'h0000, s.on_dly}, s.wdata, s.wstrb));
            ioc_pkg::OFS_OFF_DLY: nxt_s.off_dly = 16'(merge({16'h0000, s.off_dly}, s.wdata, s.wstrb));
            ioc_pkg::OFS_AO_RATE: nxt_s.rate = 16'(merge({16'h0000, s.rate}, s.wdata, s.wstrb));
            ioc_pkg::OFS_AO_SIM: nxt_s.ao_sim =
               clamp_pct(16'(merge({16'h0000, s.ao_sim}, s.wdata, s.wstrb)));
            ioc_pkg::OFS_AO_SUBST: nxt_s.ao_subst =
               clamp_pct(16'(merge({16'h0000, s.ao_subst}, s.wdata, s.wstrb)));
            ioc_pkg::OFS_STATUS: ;
            ioc_pkg::OFS_IRQ_STAT: irq_clr = wr_word[2:0];
            ioc_pkg::OFS_IRQ_MASK: nxt_s.irq_mask = 3'(merge({29'h00000000, s.irq_mask}, s.wdata, s.wstrb));
            default: nxt_s.bresp = ioc_pkg::RESP_SLVERR;
         endcase
      end
      nxt_s.awready = !nxt_s.aw_hold;
      nxt_s.wready = !nxt_s.w_hold;

      if (s_axi_arvalid && s.arready) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp = ioc_pkg::RESP_OK;
         unique case ({s_axi_araddr[7:2], 2'b00})
            ioc_pkg::OFS_CTRL: nxt_s.rdata = {19'h00000, s.ctrl};
            ioc_pkg::OFS_ON_DLY: nxt_s.rdata = {16'h0000, s.on_dly};
            ioc_pkg::OFS_OFF_DLY: nxt_s.rdata = {16'h0000, s.off_dly};
            ioc_pkg::OFS_AO_RATE: nxt_s.rdata = {16'h0000, s.rate};
            ioc_pkg::OFS_AO_SIM: nxt_s.rdata = {16'h0000, s.ao_sim};
            ioc_pkg::OFS_AO_SUBST: nxt_s.rdata = {16'h0000, s.ao_subst};
            ioc_pkg::OFS_STATUS: nxt_s.rdata = {rif.level, 12'h000, s.ao_ok, s.di_fault, s.di_ok, s.di_pv};
            ioc_pkg::OFS_IRQ_STAT: nxt_s.rdata = {29'h00000000, s.irq_stat};
            ioc_pkg::OFS_IRQ_MASK: nxt_s.rdata = {29'h00000000, s.irq_mask};
            default: begin
               nxt_s.rdata = 32'h00000000;
               nxt_s.rresp = ioc_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s.rvalid && s_axi_rready) begin
         nxt_s.rvalid = 1'b0;
      end
      nxt_s.arready = !nxt_s.rvalid;

      // Millisecond base and the 10 ms rate step
      nxt_s.ms_tick = 1'b0;
      nxt_s.rate_tick = 1'b0;
      if (s.ms_cnt == MSW'(MS_CYCLES - 1)) begin
         nxt_s.ms_cnt = '0;
         nxt_s.ms_tick = 1'b1;
      end else begin
         nxt_s.ms_cnt = s.ms_cnt + 1'b1;
      end
      if (s.ms_tick) begin
         if (s.step_cnt == 4'(ioc_pkg::RATE_STEP_MS - 1)) begin
            nxt_s.step_cnt = 4'h0;
            nxt_s.rate_tick = 1'b1;
         end else begin
            nxt_s.step_cnt = s.step_cnt + 4'h1;
         end
      end

      // Digital input path
      di_live = di_field ^ s.ctrl[ioc_pkg::B_DI_NEG];
      di_err = s.ctrl[ioc_pkg::B_DI_LFD] && di_line_fault && !s.ctrl[ioc_pkg::B_DI_SIM];
      if (!en) begin
         // Inactive channel reports nothing valid and forgets its filter history
         nxt_s.di_filt = 1'b0;
         nxt_s.di_cnt = 16'h0000;
         nxt_s.di_pv = 1'b0;
         nxt_s.di_ok = 1'b0;
         nxt_s.di_fault = 1'b0;
      end else begin
         if (di_live != s.di_filt) begin
            if (s.di_cnt >= (s.di_filt ? s.off_dly : s.on_dly)) begin
               nxt_s.di_filt = di_live;
               nxt_s.di_cnt = 16'h0000;
            end else if (s.ms_tick) begin
               nxt_s.di_cnt = s.di_cnt + 16'h0001;
            end
         end else begin
            nxt_s.di_cnt = 16'h0000;
         end
         nxt_s.di_fault = di_err;
         if (s.ctrl[ioc_pkg::B_DI_SIM]) begin
            nxt_s.di_pv = s.ctrl[ioc_pkg::B_DI_SIMV];
            nxt_s.di_ok = !s.ctrl[ioc_pkg::B_DI_SIMINV];
         end else if (di_err) begin
            nxt_s.di_ok = 1'b0;
            if (di_mode == ioc_pkg::MODE_SUB) begin
               nxt_s.di_pv = s.ctrl[ioc_pkg::B_DI_SUBV];
            end else if (di_mode == ioc_pkg::MODE_LAST) begin
               nxt_s.di_pv = s.di_last;
            end else begin
               nxt_s.di_pv = s.di_filt;
            end
         end else begin
            nxt_s.di_pv = s.di_filt;
            nxt_s.di_ok = 1'b1;
         end
      end
      if (nxt_s.di_ok) begin
         nxt_s.di_last = nxt_s.di_pv;
      end

      // Analog output path
      ao_src = clamp_pct(s.ctrl[ioc_pkg::B_AO_SIM] ? s.ao_sim : ao_bus_value);
      ao_err = ao_error || (s.ctrl[ioc_pkg::B_AO_SIM] ? s.ctrl[ioc_pkg::B_AO_SIMINV] : !ao_bus_ok);
      if (!en) begin
         nxt_s.ao_tgt = ioc_pkg::WORD16_RST;
         nxt_s.ao_ok = 1'b0;
      end else if (ao_err) begin
         nxt_s.ao_ok = 1'b0;
         if (ao_mode == ioc_pkg::MODE_SUB) begin
            nxt_s.ao_tgt = s.ao_subst;
         end else if (ao_mode == ioc_pkg::MODE_LAST) begin
            nxt_s.ao_tgt = s.ao_last;
         end else begin
            nxt_s.ao_tgt = ao_src;
         end
      end else begin
         nxt_s.ao_tgt = ao_src;
         nxt_s.ao_ok = 1'b1;
         nxt_s.ao_last = ao_src;
      end

      // A new event wins over a clear written in the same cycle
      ev[ioc_pkg::IRQ_DI_FAULT] = nxt_s.di_fault && !s.di_fault;
      ev[ioc_pkg::IRQ_DI_CHG] = nxt_s.di_pv != s.di_pv;
      ev[ioc_pkg::IRQ_AO_ERR] = s.ao_ok && !nxt_s.ao_ok && en;
      nxt_s.irq_stat = (s.irq_stat & ~irq_clr) | ev;
      nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= nxt_s;
      end
   end

   assign rif.target = s.ao_tgt;
   assign rif.rate = s.rate;
   assign rif.tick = s.rate_tick;
   assign rif.clear = !en;

   ioc_ramp u_ramp (
      .clk_sys(clk_sys),
      .rst(rst),
      .rp(rif)
   );

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bresp = s.bresp;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_arready = s.arready;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rvalid = s.rvalid;
   assign di_value = s.di_pv;
   assign di_value_ok = s.di_ok;
   assign ao_value = rif.level;
   assign ao_value_ok = s.ao_ok;
   assign irq = s.irq;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence di_sim_on;
      en && s.ctrl[ioc_pkg::B_DI_SIM];
   endsequence
   sequence di_fault_on;
      en && !s.ctrl[ioc_pkg::B_DI_SIM] && s.ctrl[ioc_pkg::B_DI_LFD] && di_line_fault;
   endsequence

   di_sim_fwd_a: assert property (di_sim_on |=> (s.di_pv == $past(s.ctrl[ioc_pkg::B_DI_SIMV])) &&
      (s.di_ok == !$past(s.ctrl[ioc_pkg::B_DI_SIMINV])))
      else $error("simulation bit or status not forwarded");
   di_fault_flag_a: assert property (di_fault_on |=> !s.di_ok && s.di_fault)
      else $error("line fault not flagged");
   di_subst_a: assert property ((di_fault_on and (di_mode == ioc_pkg::MODE_SUB)) |=>
      (s.di_pv == $past(s.ctrl[ioc_pkg::B_DI_SUBV])) && !s.di_ok)
      else $error("substitute bit wrong");
   di_last_a: assert property ((di_fault_on and (di_mode == ioc_pkg::MODE_LAST)) |=>
      s.di_pv == $past(s.di_last) && s.di_last == $past(s.di_last))
      else $error("last valid value not held");
   di_neg_a: assert property ((en && s.on_dly == 16'h0000 && s.off_dly == 16'h0000) |=>
      s.di_filt == ($past(di_field) ^ $past(s.ctrl[ioc_pkg::B_DI_NEG])))
      else $error("negated level wrong");
   di_on_hold_a: assert property ((en && !s.di_filt && di_live && s.on_dly != 16'h0000 &&
      s.di_cnt == 16'h0000) |=> !s.di_filt)
      else $error("rising edge passed before ON delay");
   di_off_hold_a: assert property ((en && s.di_filt && !di_live && s.off_dly != 16'h0000 &&
      s.di_cnt == 16'h0000) |=> s.di_filt)
      else $error("falling edge passed before OFF delay");
   last_store_a: assert property ((en && nxt_s.di_ok) |=> s.di_last == s.di_pv)
      else $error("valid value not stored");
   off_quiet_a: assert property (!en |=> !s.di_ok && !s.ao_ok && !s.di_pv && s.ao_tgt == 16'h0000)
      else $error("disabled channel still active");
   ao_sim_inv_a: assert property ((en && s.ctrl[ioc_pkg::B_AO_SIM] && s.ctrl[ioc_pkg::B_AO_SIMINV]) |=>
      !s.ao_ok)
      else $error("invalid simulation marked valid");
   ao_subst_a: assert property ((en && ao_err && ao_mode == ioc_pkg::MODE_SUB) |=>
      s.ao_tgt == $past(s.ao_subst) && !s.ao_ok)
      else $error("analog substitute wrong");
   ao_range_a: assert property ($signed(s.ao_sim) >= $signed(ioc_pkg::PCT_MIN) &&
      $signed(s.ao_sim) <= $signed(ioc_pkg::PCT_MAX) && $signed(s.ao_subst) <= $signed(ioc_pkg::PCT_MAX))
      else $error("percent out of range");
endmodule
`default_nettype wire

/* File: hw/ioc_pkg.sv */
/*
 Shared constants of the I/O channel value conditioner: register map, control field
 positions, reset values, percent limits and timing counts.
 Assumes a 100 MHz system clock.
*/
package ioc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
   localparam int RATE_STEP_MS = 10;
   localparam int REG_AW = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ON_DLY = 8'h04;
   localparam logic [7:0] OFS_OFF_DLY = 8'h08;
   localparam logic [7:0] OFS_AO_RATE = 8'h0C;
   localparam logic [7:0] OFS_AO_SIM = 8'h10;
   localparam logic [7:0] OFS_AO_SUBST = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
   localparam int B_EN = 0;
   localparam int B_DI_SIM = 1;
   localparam int B_DI_NEG = 2;
   localparam int B_DI_LFD = 3;
   localparam int B_DI_MODE = 4;
   localparam int B_DI_SIMV = 6;
   localparam int B_DI_SIMINV = 7;
   localparam int B_DI_SUBV = 8;
   localparam int B_AO_SIM = 9;
   localparam int B_AO_SIMINV = 10;
   localparam int B_AO_MODE = 11;
   localparam int CTRL_W = 13;
   localparam logic [1:0] MODE_CUR = 2'h0;
   localparam logic [1:0] MODE_SUB = 2'h1;
   localparam logic [1:0] MODE_LAST = 2'h2;
   localparam logic [12:0] CTRL_RST = 13'h0000;
   localparam logic [15:0] WORD16_RST = 16'h0000;
   localparam logic [15:0] PCT_MIN = 16'hF63C;
   localparam logic [15:0] PCT_MAX = 16'h30D4;
   localparam int IRQ_W = 3;
   localparam int IRQ_DI_FAULT = 0;
   localparam int IRQ_DI_CHG = 1;
   localparam int IRQ_AO_ERR = 2;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hw/ioc_ramp_if.sv */
/*
 Link between the channel core and its analog rate limiter.
 Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface ioc_ramp_if;
   logic [15:0] target;
   logic [15:0] rate;
   logic tick;
   logic clear;
   logic [15:0] level;
   modport ctl (output target, output rate, output tick, output clear, input level);
   modport ramp (input target, input rate, input tick, input clear, output level);
endinterface
`default_nettype wire

/* File: hw/ioc_ramp.sv */
/*
 Analog output rate limiter: moves the level toward the target by at most rate
 hundredths of a percent per tick.
 Assumes one tick every 10 ms, so rate in percent per second equals the step size.
*/
`timescale 1ns/1ps
`default_nettype none
module ioc_ramp (
   input wire logic clk_sys,
   input wire logic rst,
   ioc_ramp_if.ramp rp
);
   typedef struct packed {
      logic [15:0] level;
   } ioc_ramp_state_type;

   ioc_ramp_state_type s;
   ioc_ramp_state_type nxt_s;
   logic signed [16:0] diff;
   logic signed [16:0] rate_s;

   always_comb begin
      nxt_s = s;
      diff = $signed({rp.target[15], rp.target}) - $signed({s.level[15], s.level});
      rate_s = $signed({1'b0, rp.rate});
      if (rp.clear) begin
         nxt_s.level = ioc_pkg::WORD16_RST;
      end else if (rp.rate == ioc_pkg::WORD16_RST) begin
         nxt_s.level = rp.target;
      end else if (rp.tick) begin
         // Step never overshoots, so the sum cannot wrap
         if (diff > rate_s) begin
            nxt_s.level = s.level + rp.rate;
         end else if (diff < -rate_s) begin
            nxt_s.level = s.level - rp.rate;
         end else begin
            nxt_s.level = rp.target;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= nxt_s;
      end
   end

   assign rp.level = s.level;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   ramp_pass_a: assert property (
      (!rp.clear && rp.rate == 16'h0000) |=> s.level == $past(rp.target))
      else $error("zero rate did not pass target");
   ramp_hold_a: assert property (
      (!rp.clear && rp.rate != 16'h0000 && !rp.tick) |=> $stable(s.level))
      else $error("level moved without tick");
   ramp_step_a: assert property (
      (!rp.clear && rp.rate != 16'h0000 && rp.tick) |=>
      ($signed({{2{s.level[15]}}, s.level}) - $signed({{2{$past(s.level[15])}}, $past(s.level)})
         <= $signed({2'b00, $past(rp.rate)})) &&
      ($signed({{2{$past(s.level[15])}}, $past(s.level)}) - $signed({{2{s.level[15]}}, s.level})
         <= $signed({2'b00, $past(rp.rate)})))
      else $error("step exceeded rate");
endmodule
`default_nettype wire

/* File: tb/ioc_field_model.sv */
/*
 Field side stand-in: digital contact with lead breakage, and the control system's analog value.
 Assumes the bench changes its commands just after a clk_sys edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ioc_field_model (
   input wire logic clk_sys,
   input wire logic lv_cmd,
   input wire logic flt_cmd,
   input wire logic [15:0] av_cmd,
   input wire logic aok_cmd,
   input wire logic aer_cmd,
   output logic di_field,
   output logic di_line_fault,
   output logic [15:0] ao_bus_value,
   output logic ao_bus_ok,
   output logic ao_error
);
   initial begin
      di_field = 1'b0;
      di_line_fault = 1'b0;
      ao_bus_value = 16'h0000;
      ao_bus_ok = 1'b0;
      ao_error = 1'b0;
   end
   always @(posedge clk_sys) begin
      di_line_fault <= flt_cmd;
      // A broken lead reads as noise, toggling every cycle instead of holding the last good level
      di_field <= di_line_fault ? ~di_field : lv_cmd;
      // Invalid bus data means nothing, so it is scrambled
      ao_bus_value <= aok_cmd ? av_cmd : ~ao_bus_value;
      ao_bus_ok <= aok_cmd;
      ao_error <= aer_cmd;
   end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
 Self-checking bench for ioc_core: registers over AXI4-Lite, field stimulus through the field model.
 Assumes MS_CYCLES of 10, so one millisecond is ten clk_sys cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [31:0] EN = 32'h1 << ioc_pkg::B_EN;
   localparam logic [31:0] LFD = 32'h1 << ioc_pkg::B_DI_LFD;
   localparam logic [31:0] AOS = 32'h1 << ioc_pkg::B_AO_SIM;
   localparam logic [31:0] AOSUB = {30'h0, ioc_pkg::MODE_SUB} << ioc_pkg::B_AO_MODE;
   localparam logic [1:0] OK = ioc_pkg::RESP_OK;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic lv = 1'b0, flt = 1'b0, aok = 1'b1, aer = 1'b0;
   logic [15:0] av = 16'h0000;
   logic awready, wready, bvalid, arready, rvalid, di_value, di_value_ok, ao_value_ok, irq;
   logic di_field, di_line_fault, ao_bus_ok, ao_error;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] ao_bus_value, ao_value;
   int bad_count = 0;
   int n_compared = 0;

   always #5 clk_sys = ~clk_sys;

   ioc_field_model fm (.clk_sys(clk_sys), .lv_cmd(lv), .flt_cmd(flt), .av_cmd(av), .aok_cmd(aok),
      .aer_cmd(aer), .di_field(di_field), .di_line_fault(di_line_fault), .ao_bus_value(ao_bus_value),
      .ao_bus_ok(ao_bus_ok), .ao_error(ao_error));

   ioc_core #(.MS_CYCLES(10)) uut (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .di_field(di_field), .di_line_fault(di_line_fault), .ao_bus_value(ao_bus_value),
      .ao_bus_ok(ao_bus_ok), .ao_error(ao_error), .di_value(di_value), .di_value_ok(di_value_ok),
      .ao_value(ao_value), .ao_value_ok(ao_value_ok), .irq(irq));

   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // A missing answer leaves a response of 3, which no check expects
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic [1:0] r;
      @(posedge clk_sys);
      n = 0;
      r = 2'h3;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (r == 2'h3 && n < 500) begin
         @(posedge clk_sys);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            bready <= 1'b0;
            r = bresp;
         end
      end
      chk("bresp", er, r);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
      int n;
      logic [1:0] r;
      logic [31:0] d;
      @(posedge clk_sys);
      n = 0;
      r = 2'h3;
      d = ~e;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (r == 2'h3 && n < 500) begin
         @(posedge clk_sys);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rready <= 1'b0;
            r = rresp;
            d = rdata;
         end
      end
      chk(nm, e, d);
      chk("rresp", er, r);
   endtask

   initial begin
      #100us;
      bad_count++;
      $display("watchdog expired");
      give_verdict;
   end

   initial begin
      logic [1:0] md;
      wt(20);
      rst <= 1'b0;
      wt(2);
      chk("irq after reset", 32'h0, irq);
      rdc(ioc_pkg::OFS_CTRL, 32'h0, OK, "ctrl reset");
      rdc(8'h40, 32'h0, ioc_pkg::RESP_SLVERR, "unmapped read");
      wr(8'h40, 32'hFFFFFFFF, ioc_pkg::RESP_SLVERR);
      $display("test registers done");
      lv <= 1'b1;
      wt(6);
      chk("di disabled", 32'h0, di_value);
      wr(ioc_pkg::OFS_CTRL, EN, OK);
      wt(6);
      chk("di live", 32'h1, di_value);
      chk("di live ok", 32'h1, di_value_ok);
      wr(ioc_pkg::OFS_CTRL, EN | (32'h1 << ioc_pkg::B_DI_NEG), OK);
      wt(6);
      chk("di negated", 32'h0, di_value);
      for (int k = 0; k < 4; k++) begin
         wr(ioc_pkg::OFS_CTRL, EN | (32'h1 << ioc_pkg::B_DI_SIM) | (32'(k & 1) << ioc_pkg::B_DI_SIMV)
            | (32'(k >> 1) << ioc_pkg::B_DI_SIMINV), OK);
         wt(4);
         chk("di sim value", 32'(k & 1), di_value);
         chk("di sim status", 32'((k >> 1) ^ 1), di_value_ok);
      end
      wr(ioc_pkg::OFS_CTRL, EN, OK);
      lv <= 1'b0;
      wr(ioc_pkg::OFS_ON_DLY, 32'h2, OK);
      wt(50);
      lv <= 1'b1;
      wt(5);
      lv <= 1'b0;
      wt(40);
      chk("on short pulse", 32'h0, di_value);
      lv <= 1'b1;
      wt(45);
      chk("on long pulse", 32'h1, di_value);
      wr(ioc_pkg::OFS_ON_DLY, 32'h0, OK);
      wr(ioc_pkg::OFS_OFF_DLY, 32'h2, OK);
      lv <= 1'b0;
      wt(6);
      chk("off stretched", 32'h1, di_value);
      wt(40);
      chk("off ended", 32'h0, di_value);
      wr(ioc_pkg::OFS_OFF_DLY, 32'h0, OK);
      lv <= 1'b1;
      wt(6);
      // Field sits at 1 and the substitute at 0, so substitute and last value modes differ; live mode value is left unchecked
      for (int m = 0; m < 3; m++) begin
         md = (m == 0) ? ioc_pkg::MODE_SUB : (m == 1) ? ioc_pkg::MODE_LAST : ioc_pkg::MODE_CUR;
         wr(ioc_pkg::OFS_IRQ_MASK, (m == 0) ? 32'h0 : 32'h1 << ioc_pkg::IRQ_DI_FAULT, OK);
         wr(ioc_pkg::OFS_CTRL, EN | LFD | ({30'h0, md} << ioc_pkg::B_DI_MODE), OK);
         flt <= 1'b1;
         wt(6);
         chk("di fault status", 32'h0, di_value_ok);
         if (m < 2) chk("di fault value", 32'(m), di_value);
         chk("irq fault", 32'(m != 0), irq);
         flt <= 1'b0;
         wt(6);
         wr(ioc_pkg::OFS_IRQ_STAT, 32'h7, OK);
         wt(3);
         chk("irq cleared", 32'h0, irq);
      end
      $display("test digital done");
      wr(ioc_pkg::OFS_CTRL, EN, OK);
      av <= 16'h1000;
      wt(6);
      chk("ao direct", 32'h1000, ao_value);
      chk("ao direct ok", 32'h1, ao_value_ok);
      wr(ioc_pkg::OFS_AO_RATE, 32'h5, OK);
      av <= 16'h1100;
      wt(150);
      chk("ao ramp", 32'h1, ao_value > 16'h1000 && ao_value <= 16'h100A);
      wr(ioc_pkg::OFS_AO_RATE, 32'h0, OK);
      wt(6);
      chk("ao rate off", 32'h1100, ao_value);
      wr(ioc_pkg::OFS_AO_SIM, 32'h7FFF, OK);
      rdc(ioc_pkg::OFS_AO_SIM, {16'h0, ioc_pkg::PCT_MAX}, OK, "ao sim clamp");
      wr(ioc_pkg::OFS_CTRL, EN | AOS, OK);
      wt(6);
      chk("ao sim", {16'h0, ioc_pkg::PCT_MAX}, ao_value);
      wr(ioc_pkg::OFS_AO_SUBST, 32'h8000, OK);
      rdc(ioc_pkg::OFS_AO_SUBST, {16'h0, ioc_pkg::PCT_MIN}, OK, "ao subst clamp");
      wr(ioc_pkg::OFS_IRQ_MASK, 32'h1 << ioc_pkg::IRQ_AO_ERR, OK);
      wr(ioc_pkg::OFS_CTRL, EN | AOS | (32'h1 << ioc_pkg::B_AO_SIMINV) | AOSUB, OK);
      wt(6);
      chk("ao sim invalid", {16'h0, ioc_pkg::PCT_MIN}, ao_value);
      chk("ao sim invalid ok", 32'h0, ao_value_ok);
      chk("irq ao", 32'h1, irq);
      wr(ioc_pkg::OFS_CTRL, EN | AOSUB, OK);
      aer <= 1'b1;
      wt(6);
      chk("ao subst", {16'h0, ioc_pkg::PCT_MIN}, ao_value);
      chk("ao subst ok", 32'h0, ao_value_ok);
      aer <= 1'b0;
      wr(ioc_pkg::OFS_CTRL, EN | ({30'h0, ioc_pkg::MODE_LAST} << ioc_pkg::B_AO_MODE), OK);
      // The new bus value arrives together with the error, so only the old one was ever valid
      aer <= 1'b1;
      av <= 16'h2000;
      wt(6);
      chk("ao last", 32'h1100, ao_value);
      wr(ioc_pkg::OFS_CTRL, 32'h0, OK);
      wt(6);
      chk("ao disabled", 32'h0, ao_value);
      $display("test analog done");
      give_verdict;
   end
endmodule
`default_nettype wire
